// ### verif/sdd_link_monitor.sv
`timescale 1ns/100ps
// ************************************************************
// Link checker
// ************************************************************
module sdd_link_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Link signals
   input wire logic chipset_decode_block_output,
   input wire logic dma_bus_request_n,
   input wire logic dma_bus_grant_n,
   input wire logic sirq_dev_out,
   input wire logic sirq_dev_oe,
   input wire logic sirq_host_out,
   input wire logic sirq_host_oe,
   input wire logic serial_interrupt_line
);
   logic host_low;
   logic dev_low;
   assign host_low = sirq_host_oe & ~sirq_host_out;
   assign dev_low  = sirq_dev_oe & ~sirq_dev_out;
   // Reset checks carry no disable, since reset is their cause.
   chk_req_reset_idle: assert property (@(posedge clk_sys) rst |=> dma_bus_request_n)
      else $error("request not idle after reset");
   chk_gnt_reset_idle: assert property (@(posedge clk_sys) rst |=> dma_bus_grant_n)
      else $error("grant not idle after reset");
   chk_inhibit_at_reset: assert property (@(posedge clk_sys) rst |=> chipset_decode_block_output)
      else $error("inhibit low after reset");
   chk_inhibit_stays_low: assert property (@(posedge clk_sys) disable iff (rst)
      !chipset_decode_block_output |=> !chipset_decode_block_output)
      else $error("inhibit raised again");
   chk_grant_needs_req: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(dma_bus_grant_n) |-> !$past(dma_bus_request_n))
      else $error("grant without request");
   chk_grant_released: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(dma_bus_request_n) |-> ##[0:2] dma_bus_grant_n)
      else $error("grant held after request dropped");
   chk_start_four_clk: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(host_low) |-> host_low [*4] ##1 !host_low)
      else $error("start frame length wrong");
   chk_dev_slot_pulse: assert property (@(posedge clk_sys) disable iff (rst) dev_low |=> !dev_low)
      else $error("device slot longer than one clock");
   chk_dev_quiet_start: assert property (@(posedge clk_sys) disable iff (rst) host_low |-> !dev_low)
      else $error("device drives during start frame");
endmodule

// ### verif/tb_top.sv
`timescale 1ns/100ps
// ************************************************************
// Bench top
// ************************************************************
module tb_top;
   import sdd_pkg::*;
   localparam logic [7:0] SUB_DLY = {5'h00, SDD_SUB_SAMPLE_CLK};
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        handover_done = 1'b0;
   logic        arb_allow = 1'b0;
   logic        dev_owns_bus;
   logic        irq_seen;
   logic [4:0]  irq_slot;
   logic        bios_positive_decode_strap_n = 1'b0;
   logic        isa_ale = 1'b0;
   logic        dma_pending = 1'b0;
   logic        master_pending = 1'b0;
   logic        cyc_start = 1'b0;
   logic        cyc_mem = 1'b0;
   logic        cyc_io = 1'b0;
   logic [31:0] cyc_addr = 32'h0000_0000;
   logic        other_devsel = 1'b0;
   logic        cyc_end = 1'b0;
   logic        cfg_wr = 1'b0;
   logic [7:0]  cfg_addr = 8'h00;
   logic [7:0]  cfg_wdata = 8'h00;
   logic [20:0] irq_src = 21'h0_0000;
   logic        claim_positive;
   logic        claim_subtractive;
   logic        bus_master_en;
   logic        bpd_mode;
   logic [7:0]  fctl_value;
   int          err_total = 0;
   int          n_tests = 0;
   int          ks;
   int          kp;
   always #2.5 clk_sys = ~clk_sys;
   sdd_link_if sdd_link_if_inst ();
   sdd_device sdd_device_inst (.clk_sys, .rst, .link(sdd_link_if_inst), .bios_positive_decode_strap_n, .isa_ale,
      .dma_pending, .master_pending, .cyc_start, .cyc_mem, .cyc_io, .cyc_addr, .other_devsel, .cyc_end, .cfg_wr,
      .cfg_addr, .cfg_wdata, .irq_src, .claim_positive, .claim_subtractive, .bus_master_en, .bpd_mode, .fctl_value);
   sdd_host sdd_host_inst (.clk_sys, .rst, .link(sdd_link_if_inst), .handover_done, .arb_allow, .dev_owns_bus,
      .irq_seen, .irq_slot);
   sdd_link_monitor sdd_link_monitor_inst (.clk_sys, .rst,
      .chipset_decode_block_output(sdd_link_if_inst.chipset_decode_block_output),
      .dma_bus_request_n(sdd_link_if_inst.dma_bus_request_n), .dma_bus_grant_n(sdd_link_if_inst.dma_bus_grant_n),
      .sirq_dev_out(sdd_link_if_inst.sirq_dev_out), .sirq_dev_oe(sdd_link_if_inst.sirq_dev_oe),
      .sirq_host_out(sdd_link_if_inst.sirq_host_out), .sirq_host_oe(sdd_link_if_inst.sirq_host_oe),
      .serial_interrupt_line(sdd_link_if_inst.serial_interrupt_line));
   function automatic logic [7:0] b(input logic x);
      return {7'h00, x};
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic pci_cyc(input logic [31:0] a, input logic mem, input int dsel);
      ks = 0;
      kp = 0;
      cyc_addr = a;
      cyc_mem = mem;
      cyc_io = ~mem;
      cyc_start = 1'b1;
      tick(1);
      cyc_start = 1'b0;
      for (int i = 1; i <= 8; i++) begin
         if (i == dsel) other_devsel = 1'b1;
         tick(1);
         if (kp == 0 && claim_positive === 1'b1) kp = i;
         if (ks == 0 && claim_subtractive === 1'b1) ks = i;
      end
      cyc_end = 1'b1;
      other_devsel = 1'b0;
      tick(1);
      cyc_end = 1'b0;
      tick(1);
      chk("claims released", 8'h00, {6'h00, claim_positive, claim_subtractive});
   endtask
   task automatic t_reset();
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      chk("fctl reset", SDD_FCTL_RESET, fctl_value);
      chk("request idle", 8'h01, b(sdd_link_if_inst.dma_bus_request_n));
      chk("inhibit at reset", 8'h01, b(sdd_link_if_inst.chipset_decode_block_output));
      bios_positive_decode_strap_n = 1'b1;
      isa_ale = 1'b1;
      tick(1);
      isa_ale = 1'b0;
      tick(2);
      chk("strap sampled at ale", 8'h00, b(bpd_mode));
      pci_cyc(32'h0001_0000, 1'b1, 0);
      chk("claim while inhibited", 8'h00, ks[7:0]);
      $display("test reset and inhibit done");
   endtask
   task automatic t_cfg();
      cfg_addr = 8'h43;
      cfg_wdata = 8'h55;
      cfg_wr = 1'b1;
      tick(1);
      chk("fctl other offset", SDD_FCTL_RESET, fctl_value);
      cfg_addr = SDD_FCTL_ADDR;
      cfg_wdata = SDD_FCTL_INIT;
      tick(1);
      cfg_wr = 1'b0;
      tick(1);
      chk("fctl written", SDD_FCTL_INIT, fctl_value);
      $display("test config done");
   endtask
   task automatic t_sub();
      handover_done = 1'b1;
      tick(1);
      handover_done = 1'b0;
      tick(2);
      chk("inhibit released", 8'h00, b(sdd_link_if_inst.chipset_decode_block_output));
      pci_cyc(SDD_BIOS_BASE, 1'b1, 0);
      chk("subtractive delay", SUB_DLY, ks[7:0]);
      chk("no positive without strap", 8'h00, kp[7:0]);
      pci_cyc(32'h0000_0300, 1'b0, 2);
      chk("other agent claimed", 8'h00, ks[7:0]);
      $display("test subtractive done");
   endtask
   task automatic t_arb();
      arb_allow = 1'b1;
      dma_pending = 1'b1;
      tick(1);
      chk("request asserted", 8'h00, b(sdd_link_if_inst.dma_bus_request_n));
      chk("no master before grant", 8'h00, b(bus_master_en));
      tick(2);
      chk("owned after grant", 8'h03, {6'h00, bus_master_en, dev_owns_bus});
      arb_allow = 1'b0;
      tick(3);
      chk("grant removed", 8'h00, b(bus_master_en));
      dma_pending = 1'b0;
      master_pending = 1'b1;
      arb_allow = 1'b1;
      tick(3);
      chk("master owns bus", 8'h01, b(bus_master_en));
      master_pending = 1'b0;
      tick(3);
      chk("request released", 8'h01, b(sdd_link_if_inst.dma_bus_request_n));
      $display("test arbitration done");
   endtask
   task automatic t_sirq();
      int s;
      for (int j = 0; j < 2; j++) begin
         s = (j == 0) ? 3 : SDD_SIRQ_FRAMES - 1;
         irq_src = 21'h0_0001 << s;
         for (int k = 0; k < 400 && irq_seen !== 1'b1; k++) tick(1);
         chk("irq seen", 8'h01, b(irq_seen));
         chk("irq slot", s[7:0], {3'h0, irq_slot});
         irq_src = 21'h0_0000;
         tick(1);
      end
      $display("test serial interrupt done");
   endtask
   task automatic t_strap();
      bios_positive_decode_strap_n = 1'b0;
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(2);
      isa_ale = 1'b1;
      tick(1);
      isa_ale = 1'b0;
      bios_positive_decode_strap_n = 1'b1;
      tick(2);
      chk("strap mode taken", 8'h01, b(bpd_mode));
      isa_ale = 1'b1;
      tick(1);
      isa_ale = 1'b0;
      tick(2);
      chk("strap mode frozen", 8'h01, b(bpd_mode));
      pci_cyc(SDD_BIOS_BASE, 1'b1, 0);
      chk("bios low positive", 8'h01, kp[7:0]);
      chk("bios not subtractive", 8'h00, ks[7:0]);
      pci_cyc(SDD_BIOS_HI_BASE, 1'b1, 0);
      chk("bios high positive", 8'h01, kp[7:0]);
      pci_cyc(SDD_BIOS_LIMIT + 32'h0000_0001, 1'b1, 0);
      chk("outside bios", SUB_DLY, ks[7:0]);
      pci_cyc(SDD_BIOS_BASE, 1'b0, 0);
      chk("io in bios range", SUB_DLY, ks[7:0]);
      $display("test strap done");
   endtask
   initial begin
      t_reset();
      t_cfg();
      t_sub();
      t_arb();
      t_sirq();
      t_strap();
      end_sim();
   end
   // Generous bound: the tests need well under a tenth of this span.
   initial begin
      #100000;
      err_total++;
      end_sim();
   end
endmodule

// ### verilog/sdd_device.sv
`timescale 1ns/100ps

// Functional notes
// R1: inhibit input blocks subtractive claiming
// R2: strap low at first latch-enable overrides inhibit
// R3: strap mode positively claims BIOS range
// R4: strap mode still subtractively decodes others
// R5: request output asserted for pending DMA/master
// R6: drive bus only after grant
// R7: arbiter asserts grant to hand ownership
// R8: interrupts reported over serial line
// R9: chipset holds inhibit high until handover
// R10: host runs continuous, 21 frames, 4-clock start
// R11: software writes 20h to offset 42h
// R12: function control register resets to 28h
// R13: subtractive claim only after sampling point
module sdd_device (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Link
   sdd_link_if.device       link,
   // Strap and ISA status
   input  wire logic        bios_positive_decode_strap_n,
   input  wire logic        isa_ale,
   input  wire logic        dma_pending,
   input  wire logic        master_pending,
   // PCI cycle view
   input  wire logic        cyc_start,
   input  wire logic        cyc_mem,
   input  wire logic        cyc_io,
   input  wire logic [31:0] cyc_addr,
   input  wire logic        other_devsel,
   input  wire logic        cyc_end,
   // Configuration access to the control byte
   input  wire logic        cfg_wr,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [7:0]  cfg_wdata,
   // Interrupt sources, one per serial frame
   input  wire logic [20:0] irq_src,
   // Outputs
   output logic             claim_positive,
   output logic             claim_subtractive,
   output logic             bus_master_en,
   output logic             bpd_mode,
   output logic [7:0]       fctl_value
);
   import sdd_pkg::*;

   sdd_dec_state_type dec_q;
   sdd_arb_state_type arb_q;
   logic        strap_taken_q;
   logic        bpd_q;
   logic [2:0]  sub_cnt_q;
   logic        pos_q;
   logic        sub_q;
   logic        own_q;
   logic        req_q;
   logic [7:0]  fctl_q;
   logic        in_bios;
   logic        inhibit;
   logic [2:0]  sq_phase_q;
   logic [4:0]  sq_frame_q;
   logic [1:0]  sq_idle_q;
   logic        sq_run_q;
   logic        sq_out_q;
   logic        sq_oe_q;

   // ************************************************************
   // Strap capture
   // ************************************************************
   // R2: sample strap at first latch enable
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         strap_taken_q <= 1'b0;
         bpd_q         <= 1'b0;
      end else if (!strap_taken_q && isa_ale) begin
         strap_taken_q <= 1'b1;
         bpd_q         <= ~bios_positive_decode_strap_n;
      end
   end

   assign in_bios = (cyc_addr >= SDD_BIOS_BASE && cyc_addr <= SDD_BIOS_LIMIT) || (cyc_addr >= SDD_BIOS_HI_BASE);
   // R1: inhibit unless strap mode
   assign inhibit = link.chipset_decode_block_output & ~bpd_q;

   // ************************************************************
   // Decode
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dec_q     <= SDD_DEC_IDLE;
         sub_cnt_q <= 3'h0;
         pos_q     <= 1'b0;
         sub_q     <= 1'b0;
      end else begin
         unique case (dec_q)
            SDD_DEC_IDLE: begin
               if (cyc_start && (cyc_mem || cyc_io)) begin
                  // R3: positive claim of BIOS range
                  if (bpd_q && cyc_mem && in_bios) begin
                     pos_q <= 1'b1;
                     dec_q <= SDD_DEC_DONE;
                  // R4: others stay subtractive
                  end else if (!inhibit) begin
                     sub_cnt_q <= 3'h0;
                     dec_q     <= SDD_DEC_WAIT;
                  end
               end
            end
            SDD_DEC_WAIT: begin
               // R13: back off if another agent claims
               if (other_devsel || cyc_end) begin
                  dec_q <= SDD_DEC_IDLE;
               end else if (sub_cnt_q == SDD_SUB_SAMPLE_CLK - 3'h1) begin
                  sub_q <= 1'b1;
                  dec_q <= SDD_DEC_DONE;
               end else begin
                  sub_cnt_q <= sub_cnt_q + 3'h1;
               end
            end
            SDD_DEC_DONE: begin
               if (cyc_end) begin
                  pos_q <= 1'b0;
                  sub_q <= 1'b0;
                  dec_q <= SDD_DEC_IDLE;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // Bus arbitration
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         arb_q <= SDD_ARB_IDLE;
         req_q <= 1'b0;
         own_q <= 1'b0;
      end else begin
         unique case (arb_q)
            SDD_ARB_IDLE: begin
               // R5: request when work pending
               if (dma_pending || master_pending) begin
                  req_q <= 1'b1;
                  arb_q <= SDD_ARB_REQ;
               end
            end
            SDD_ARB_REQ: begin
               // R6: master only once granted
               if (!link.dma_bus_grant_n) begin
                  own_q <= 1'b1;
                  arb_q <= SDD_ARB_OWN;
               end else if (!(dma_pending || master_pending)) begin
                  req_q <= 1'b0;
                  arb_q <= SDD_ARB_IDLE;
               end
            end
            SDD_ARB_OWN: begin
               // Ownership ends at once if the arbiter pulls the grant.
               if (!(dma_pending || master_pending) || link.dma_bus_grant_n) begin
                  req_q <= 1'b0;
                  own_q <= 1'b0;
                  arb_q <= SDD_ARB_IDLE;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // Function control byte
   // ************************************************************
   // R12: reset value, read/write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fctl_q <= SDD_FCTL_RESET;
      end else if (cfg_wr && cfg_addr == SDD_FCTL_ADDR) begin
         fctl_q <= cfg_wdata;
      end
   end

   // ************************************************************
   // Serial interrupt slave
   // ************************************************************
   // Start frame is detected as the line low for four clocks; the host must keep continuous mode.
   // R8: drive low in own frame slot
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sq_idle_q  <= 2'h0;
         sq_run_q   <= 1'b0;
         sq_phase_q <= 3'h0;
         sq_frame_q <= 5'h00;
         sq_out_q   <= 1'b1;
         sq_oe_q    <= 1'b0;
      end else if (!sq_run_q) begin
         sq_oe_q <= 1'b0;
         if (!link.serial_interrupt_line) begin
            if (sq_idle_q == SDD_SIRQ_START_CLK[1:0] - 2'h1) begin
               sq_run_q   <= 1'b1;
               sq_phase_q <= 3'h0;
               sq_frame_q <= 5'h00;
            end else begin
               sq_idle_q <= sq_idle_q + 2'h1;
            end
         end else begin
            sq_idle_q <= 2'h0;
         end
      end else begin
         sq_idle_q <= 2'h0;
         sq_out_q  <= 1'b0;
         sq_oe_q   <= (sq_phase_q == 3'h0) && irq_src[sq_frame_q];
         if (sq_phase_q == SDD_SIRQ_PHASE_CLK - 3'h1) begin
            sq_phase_q <= 3'h0;
            if (sq_frame_q == SDD_SIRQ_FRAMES_W - 5'h01) begin
               sq_run_q <= 1'b0;
            end else begin
               sq_frame_q <= sq_frame_q + 5'h01;
            end
         end else begin
            sq_phase_q <= sq_phase_q + 3'h1;
         end
      end
   end

   assign link.dma_bus_request_n = ~req_q;
   assign link.sirq_dev_out      = sq_out_q;
   assign link.sirq_dev_oe       = sq_oe_q;
   assign claim_positive         = pos_q;
   assign claim_subtractive      = sub_q;
   assign bus_master_en          = own_q;
   assign bpd_mode               = bpd_q;
   assign fctl_value             = fctl_q;
endmodule

// ### verilog/sdd_host.sv
`timescale 1ns/100ps
module sdd_host (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Link
   sdd_link_if.host  link,
   // User side
   input  wire logic handover_done,
   input  wire logic arb_allow,
   output logic      dev_owns_bus,
   output logic      irq_seen,
   output logic [4:0] irq_slot
);
   import sdd_pkg::*;

   logic       block_q;
   logic       gnt_q;
   logic       own_q;
   logic       seen_q;
   logic [4:0] slot_q;
   logic [4:0] frame_q;
   logic [2:0] phase_q;
   logic       start_q;

   // ************************************************************
   // Decode inhibit
   // ************************************************************
   // R9: hold inhibit until handover
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         block_q <= 1'b1;
      end else if (handover_done) begin
         block_q <= 1'b0;
      end
   end

   // ************************************************************
   // Arbiter
   // ************************************************************
   // R7: grant while request held and arb_allow high
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gnt_q <= 1'b1;
         own_q <= 1'b0;
      end else begin
         gnt_q <= ~(~link.dma_bus_request_n & arb_allow);
         own_q <= ~gnt_q & ~link.dma_bus_request_n;
      end
   end

   // ************************************************************
   // Serial interrupt host, continuous mode
   // ************************************************************
   // R10: 21 frames, 4 clock start
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         start_q <= 1'b1;
         phase_q <= 3'h0;
         frame_q <= 5'h00;
         seen_q  <= 1'b0;
         slot_q  <= 5'h00;
      end else if (start_q) begin
         seen_q <= 1'b0;
         if (phase_q == SDD_SIRQ_START_CLK - 3'h1) begin
            start_q <= 1'b0;
            phase_q <= 3'h0;
            frame_q <= 5'h00;
         end else begin
            phase_q <= phase_q + 3'h1;
         end
      end else begin
         seen_q <= 1'b0;
         // The device registers its slot driver, so its low shows one clock into the frame.
         if (phase_q == 3'h1 && !link.serial_interrupt_line) begin
            seen_q <= 1'b1;
            slot_q <= frame_q;
         end
         if (phase_q == SDD_SIRQ_PHASE_CLK - 3'h1) begin
            phase_q <= 3'h0;
            if (frame_q == SDD_SIRQ_FRAMES_W - 5'h01) begin
               start_q <= 1'b1;
            end else begin
               frame_q <= frame_q + 5'h01;
            end
         end else begin
            phase_q <= phase_q + 3'h1;
         end
      end
   end

   assign link.chipset_decode_block_output = block_q;
   assign link.dma_bus_grant_n             = gnt_q;
   assign link.sirq_host_out               = 1'b0;
   assign link.sirq_host_oe                = start_q;
   assign dev_owns_bus                     = own_q;
   assign irq_seen                         = seen_q;
   assign irq_slot                         = slot_q;
endmodule

// ### verilog/sdd_link_if.sv
`timescale 1ns/100ps
interface sdd_link_if;
   // Decode inhibit from the chipset.
   logic chipset_decode_block_output;
   // Bus request and grant, active low.
   logic dma_bus_request_n;
   logic dma_bus_grant_n;
   // Serial interrupt line, open drain style with pull-up.
   logic sirq_dev_out;
   logic sirq_dev_oe;
   logic sirq_host_out;
   logic sirq_host_oe;
   logic serial_interrupt_line;

   assign serial_interrupt_line = (sirq_dev_oe ? sirq_dev_out : 1'b1) & (sirq_host_oe ? sirq_host_out : 1'b1);

   modport device (
      input  chipset_decode_block_output,
      output dma_bus_request_n,
      input  dma_bus_grant_n,
      output sirq_dev_out,
      output sirq_dev_oe,
      input  serial_interrupt_line
   );

   modport host (
      output chipset_decode_block_output,
      input  dma_bus_request_n,
      output dma_bus_grant_n,
      output sirq_host_out,
      output sirq_host_oe,
      input  serial_interrupt_line
   );
endinterface

// ### verilog/sdd_pkg.sv
package sdd_pkg;

   // ************************************************************
   // Decode, control byte and serial interrupt constants
   // ************************************************************
   localparam logic [31:0] SDD_BIOS_BASE      = 32'h000E_0000;
   localparam logic [31:0] SDD_BIOS_LIMIT     = 32'h000F_FFFF;
   localparam logic [31:0] SDD_BIOS_HI_BASE   = 32'hFFF0_0000;
   localparam logic [7:0]  SDD_FCTL_ADDR      = 8'h42;
   localparam logic [7:0]  SDD_FCTL_RESET     = 8'h28;
   localparam logic [7:0]  SDD_FCTL_INIT      = 8'h20;
   localparam logic [2:0]  SDD_SUB_SAMPLE_CLK = 3'h4;
   localparam int          SDD_SIRQ_FRAMES    = 21;
   localparam logic [4:0]  SDD_SIRQ_FRAMES_W  = 5'h15;
   localparam logic [2:0]  SDD_SIRQ_START_CLK = 3'h4;
   localparam logic [2:0]  SDD_SIRQ_PHASE_CLK = 3'h3;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      SDD_DEC_IDLE,
      SDD_DEC_WAIT,
      SDD_DEC_DONE
   } sdd_dec_state_type;

   typedef enum logic [1:0] {
      SDD_ARB_IDLE,
      SDD_ARB_REQ,
      SDD_ARB_OWN
   } sdd_arb_state_type;

endpackage
